// ### src/three_wire_serial_pkg.sv
// constants shared by the three-wire serial port, its checker and its bench
// assumes an 8-bit register port with a 16-bit address
package three_wire_serial_pkg;
  localparam logic [15:0] MODE_ADDR   = 16'hff80;
  localparam logic [15:0] CLKSEL_ADDR = 16'hff81;
  localparam logic [15:0] TXBUF_ADDR  = 16'hff82;
  localparam logic [15:0] SHIFT_ADDR  = 16'hff83;

  localparam int EN_BIT     = 7;
  localparam int TRMD_BIT   = 6;
  localparam int DIR_BIT    = 4;
  localparam int STATUS_BIT = 0;
  localparam int CKP_BIT    = 4;
  localparam int DAP_BIT    = 3;
  localparam int CKS_LSB    = 0;

  localparam logic [7:0] MODE_WMASK   = 8'hd0;
  localparam logic [7:0] CLKSEL_WMASK = 8'h1f;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] CLKSEL_RESET = 8'h00;
  localparam logic [7:0] TXBUF_RESET  = 8'h00;
  localparam logic [7:0] SHIFT_RESET  = 8'h00;
  localparam logic [7:0] RX_FILL      = 8'h00;

  localparam logic [2:0] CKS_EXTERNAL = 3'h7;
  localparam int         WORD_BITS    = 8;
  localparam logic [4:0] LAST_EDGE    = 5'h10;
  localparam int         FIFO_DEPTH   = 8;

  typedef enum logic [1:0]
  {
    LINK_IDLE = 2'b01,
    LINK_RUN  = 2'b10
  } link_state_type;
endpackage

// ### src/word_stream_if.sv
// valid/ready word stream between the port and its fifo
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface word_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### src/word_fifo.sv
// flip-flop word fifo with valid/ready on both sides
// assumes DEPTH is a power of two; flush empties it at once
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic   clk,
  input  wire logic   nrst,
  input  wire logic   flush,
  word_stream_if.snk  fill,
  word_stream_if.src  drain
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign fill.ready  = cnt_q != FULL_COUNT;
  assign drain.valid = cnt_q != '0;
  assign drain.data  = mem_q[rp_q];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_ff @(posedge clk)
  begin
    if (!nrst || flush)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // entries need no reset: only read once counted in
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge clk)
    begin
      if (push && wp_q == AW'(i))
        mem_q[i] <= fill.data;
    end
  end
endmodule

// ### src/three_wire_serial_port.sv
// three-wire clocked serial port with its register port
// assumes link_clk runs free; pins arrive unsynchronised
`timescale 1ns/1ps
// Behaviour
// - two modes only: stopped and three-wire clocked serial.
// - stopped mode performs no serial transfer at all.
// - three-wire mode moves 8-bit words on clock, input and output lines.
// - each transmit-mode transfer shifts out and samples in together.
// - bit order selectable, MSB first or LSB first.
// - enable and transmit mode set: transmit buffer write starts a transfer.
// - written word goes through shift register onto the output line.
// - transmit buffer is 8-bit read/write, reset to 00h.
// - shift register is 8-bit, read-only to software, reset to 00h.
// - receive-only mode: reading the shift register starts a reception.
// - each sampled input bit is shifted into the shift register.
// - transmit control plus clock start/stop and phase control.
// - clearing enable stops, clearing busy flag and shift register.
// - output line held low while transmit mode bit is 0.
// - busy flag is read-only bit 0, 1 during a transfer.
// - four clock phase types from polarity and phase, type 1 at reset.
module three_wire_serial_port #(
  parameter int FIFO_DEPTH = three_wire_serial_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        link_clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic        serial_clock_line_in,
  output logic             serial_clock_line_out,
  output logic             serial_clock_line_oe,
  input  wire logic        serial_input_line,
  output logic             serial_output_line
);
  // bus clock domain
  logic [7:0] mode_q;
  logic [7:0] clksel_q;
  logic [7:0] txbuf_q;
  logic [7:0] shift_q;
  logic [7:0] rdata_q;
  logic [7:0] xfer_q;
  logic       pend_q;
  logic       req_q;
  logic       ack_s1_q;
  logic       ack_s2_q;
  logic       ack_seen_q;
  logic       enable;
  logic       trmd;
  logic       busy;
  logic       start_tx;
  logic       start_rx;
  logic       launch;
  logic       done;

  // link clock domain
  three_wire_serial_pkg::link_state_type state_q;
  logic       lrst_s1_q;
  logic       lrst_n_q;
  logic       en_s1_q;
  logic       en_s2_q;
  logic       req_s1_q;
  logic       req_s2_q;
  logic       req_seen_q;
  logic       sck_s1_q;
  logic       sck_s2_q;
  logic       sck_prev_q;
  logic       si_s1_q;
  logic       si_s2_q;
  logic [6:0] cnt_q;
  logic [4:0] edge_q;
  logic [7:0] sr_q;
  logic [7:0] rx_q;
  logic       samp_q;
  logic       sck_q;
  logic       sck_oe_q;
  logic       so_q;
  logic       ack_q;
  logic       master;
  logic       idle_lvl;
  logic       dap;
  logic       dir;
  logic [6:0] half_lim;
  logic       tick;
  logic [4:0] edge_n;
  logic       odd;
  logic       sample_now;
  logic       shift_now;

  word_stream_if #(.WIDTH(8)) fill_if ();
  word_stream_if #(.WIDTH(8)) drain_if ();

  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic       b,
                                          input logic       lsb_first);
    shift_in = lsb_first ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  assign enable   = mode_q[three_wire_serial_pkg::EN_BIT];
  assign trmd     = mode_q[three_wire_serial_pkg::TRMD_BIT];
  // fifo holding words means a transfer is already under way
  assign busy     = pend_q || drain_if.valid;
  assign start_tx = bus_wr && bus_addr == three_wire_serial_pkg::TXBUF_ADDR
                    && enable && trmd;
  assign start_rx = bus_rd && bus_addr == three_wire_serial_pkg::SHIFT_ADDR
                    && enable && !trmd;
  assign launch   = drain_if.valid && drain_if.ready;
  assign done     = ack_s2_q != ack_seen_q && pend_q;

  // a full fifo drops the start; software should have waited for idle
  assign fill_if.valid  = start_tx || start_rx;
  assign fill_if.data   = start_tx ? bus_wdata
                                   : three_wire_serial_pkg::RX_FILL;
  assign drain_if.ready = !pend_q && enable;

  word_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .nrst  (nrst),
    .flush (!enable),
    .fill  (fill_if),
    .drain (drain_if)
  );

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mode_q   <= three_wire_serial_pkg::MODE_RESET;
      clksel_q <= three_wire_serial_pkg::CLKSEL_RESET;
    end
    else if (bus_wr && bus_addr == three_wire_serial_pkg::MODE_ADDR)
      mode_q <= bus_wdata & three_wire_serial_pkg::MODE_WMASK;
    else if (bus_wr && bus_addr == three_wire_serial_pkg::CLKSEL_ADDR)
      clksel_q <= bus_wdata & three_wire_serial_pkg::CLKSEL_WMASK;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      txbuf_q <= three_wire_serial_pkg::TXBUF_RESET;
    else if (bus_wr && bus_addr == three_wire_serial_pkg::TXBUF_ADDR)
      txbuf_q <= bus_wdata;
  end

  // handshake toward the link: xfer_q stays still while req is open
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      xfer_q     <= 8'h00;
      req_q      <= 1'b0;
      pend_q     <= 1'b0;
      ack_s1_q   <= 1'b0;
      ack_s2_q   <= 1'b0;
      ack_seen_q <= 1'b0;
    end
    else
    begin
      ack_s1_q   <= ack_q;
      ack_s2_q   <= ack_s1_q;
      ack_seen_q <= ack_s2_q;
      if (!enable)
        pend_q <= 1'b0;
      else if (launch)
      begin
        xfer_q <= drain_if.data;
        req_q  <= !req_q;
        pend_q <= 1'b1;
      end
      else if (done)
        pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      shift_q <= three_wire_serial_pkg::SHIFT_RESET;
    else if (!enable)
      shift_q <= three_wire_serial_pkg::SHIFT_RESET;
    else if (done)
      shift_q <= rx_q;
  end

  // read data lands one cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata_q <= 8'h00;
    else if (bus_rd)
    begin
      case (bus_addr)
        three_wire_serial_pkg::MODE_ADDR:
          rdata_q <= {mode_q[7:1], busy};
        three_wire_serial_pkg::CLKSEL_ADDR:
          rdata_q <= clksel_q;
        three_wire_serial_pkg::TXBUF_ADDR:
          rdata_q <= txbuf_q;
        three_wire_serial_pkg::SHIFT_ADDR:
          rdata_q <= shift_q;
        default:
          rdata_q <= 8'h00;
      endcase
    end
  end

  // link side: clksel_q is static while enabled, so it is read directly
  assign master   = clksel_q[2:0] != three_wire_serial_pkg::CKS_EXTERNAL;
  assign idle_lvl = !clksel_q[three_wire_serial_pkg::CKP_BIT];
  assign dap      = clksel_q[three_wire_serial_pkg::DAP_BIT];
  assign dir      = mode_q[three_wire_serial_pkg::DIR_BIT];
  assign half_lim = 7'((8'h01 << clksel_q[2:0]) - 8'h01);
  assign tick     = master ? cnt_q == half_lim
                           : sck_s2_q != sck_prev_q;
  assign edge_n   = edge_q + 5'h01;
  assign odd      = edge_n[0];
  assign sample_now = dap ? !odd : odd;
  assign shift_now  = dap ? odd && edge_n != 5'h01 : !odd;

  always_ff @(posedge link_clk)
  begin
    lrst_s1_q  <= nrst;
    lrst_n_q   <= lrst_s1_q;
    en_s1_q    <= enable;
    en_s2_q    <= en_s1_q;
    req_s1_q   <= req_q;
    req_s2_q   <= req_s1_q;
    sck_s1_q   <= serial_clock_line_in;
    sck_s2_q   <= sck_s1_q;
    sck_prev_q <= sck_s2_q;
    si_s1_q    <= serial_input_line;
    si_s2_q    <= si_s1_q;
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n_q)
    begin
      state_q    <= three_wire_serial_pkg::LINK_IDLE;
      req_seen_q <= 1'b0;
      ack_q      <= 1'b0;
      cnt_q      <= 7'h00;
      edge_q     <= 5'h00;
      sr_q       <= 8'h00;
      rx_q       <= 8'h00;
      samp_q     <= 1'b0;
    end
    else
    begin
      case (state_q)
        three_wire_serial_pkg::LINK_IDLE:
        begin
          if (!en_s2_q)
          begin
            req_seen_q <= req_s2_q;
            ack_q      <= req_s2_q;
          end
          else if (req_s2_q != req_seen_q)
          begin
            req_seen_q <= req_s2_q;
            sr_q       <= xfer_q;
            cnt_q      <= 7'h00;
            edge_q     <= 5'h00;
            state_q    <= three_wire_serial_pkg::LINK_RUN;
          end
        end
        three_wire_serial_pkg::LINK_RUN:
        begin
          if (!en_s2_q)
          begin
            ack_q   <= req_seen_q;
            sr_q    <= 8'h00;
            state_q <= three_wire_serial_pkg::LINK_IDLE;
          end
          else if (tick)
          begin
            cnt_q  <= 7'h00;
            edge_q <= edge_n;
            if (edge_n == three_wire_serial_pkg::LAST_EDGE)
            begin
              rx_q    <= shift_in(sr_q, dap ? si_s2_q : samp_q,
                                  dir);
              ack_q   <= req_seen_q;
              state_q <= three_wire_serial_pkg::LINK_IDLE;
            end
            else if (sample_now)
              samp_q <= si_s2_q;
            else if (shift_now)
              sr_q <= shift_in(sr_q, samp_q, dir);
          end
          else
            cnt_q <= cnt_q + 7'h01;
        end
        default:
          state_q <= three_wire_serial_pkg::LINK_IDLE;
      endcase
    end
  end

  // clock only moves while a word is running; stopped mode stays idle
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n_q)
    begin
      sck_q    <= 1'b1;
      sck_oe_q <= 1'b0;
      so_q     <= 1'b0;
    end
    else
    begin
      sck_oe_q <= en_s2_q && master;
      if (state_q != three_wire_serial_pkg::LINK_RUN)
        sck_q <= idle_lvl;
      else if (tick && master)
        sck_q <= !sck_q;
      if (!trmd || !en_s2_q)
        so_q <= 1'b0;
      else
        so_q <= dir ? sr_q[0] : sr_q[7];
    end
  end

  assign bus_rdata             = rdata_q;
  assign serial_clock_line_out = sck_q;
  assign serial_clock_line_oe  = sck_oe_q;
  assign serial_output_line    = so_q;
endmodule

// ### verification/serial_port_chk.sv
// assertions on the serial port's register and pin ports
// assumes bind to three_wire_serial_port, all checks on clk
`timescale 1ns/1ps
module serial_port_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  input wire logic        serial_clock_line_oe,
  input wire logic        serial_output_line
);
  localparam logic [15:0] MA = three_wire_serial_pkg::MODE_ADDR;
  localparam logic [15:0] TA = three_wire_serial_pkg::TXBUF_ADDR;
  logic [7:0] mode_q;
  logic [7:0] txb_q;
  logic [3:0] cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk)
    if (!nrst)
      mode_q <= 8'h00;
    else if (bus_wr && bus_addr == MA)
      mode_q <= bus_wdata;
  always_ff @(posedge clk)
    if (!nrst)
      txb_q <= 8'h00;
    else if (bus_wr && bus_addr == TA)
      txb_q <= bus_wdata;
  // settle time covers the link domain's sync lag
  always_ff @(posedge clk)
    if (!nrst || (bus_wr && bus_addr == MA))
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hf)
      cnt_q <= cnt_q + 4'h1;
  sequence rd_at(logic [15:0] a);
    bus_rd && bus_addr == a ##1 !bus_rd;
  endsequence
  chk_mode_read:
    assert property (rd_at(MA) |=> (bus_rdata & 8'hfe) == (mode_q & 8'hd0))
      else $error("mode register reads back wrong");
  chk_txbuf_read:
    assert property (rd_at(TA) |=> bus_rdata == txb_q)
      else $error("transmit buffer reads back wrong");
  chk_unmapped_zero:
    assert property (rd_at(16'hff84) |=> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
  chk_rdata_holds:
    assert property (!bus_rd [*2] |=> $stable(bus_rdata))
      else $error("read data moved without a read");
  chk_rx_out_low:
    assert property (cnt_q == 4'hf && !mode_q[6] |-> !serial_output_line)
      else $error("output line not low in receive mode");
  chk_stop_no_clk:
    assert property (cnt_q == 4'hf && !mode_q[7] |-> !serial_clock_line_oe)
      else $error("clock driven while stopped");
  chk_stop_clears:
    assert property ((bus_wr && bus_addr == MA && !bus_wdata[7])
      ##2 rd_at(MA) |=> !bus_rdata[0])
      else $error("busy flag survives disable");
  chk_busy_start:
    assert property ((bus_wr && bus_addr == TA && mode_q[7:6] == 2'b11)
      ##2 rd_at(MA) |=> bus_rdata[0])
      else $error("busy flag not set by transmit write");
endmodule

// ### verification/serial_peer.sv
// peripheral at the far end: type 1 or 3 timing, msb-first shifting
// assumes inv matches a clock idling low and load comes while idle
`timescale 1ns/1ps
module serial_peer (
  input  wire logic       sck,
  input  wire logic       inv,
  input  wire logic       so,
  input  wire logic       load,
  input  wire logic [7:0] word,
  output logic            si,
  output logic      [7:0] got
);
  logic [7:0] tx_q;
  wire        lead = sck ^ inv;
  assign si = tx_q[7];
  // lead falls on the first edge of each bit for either idle level
  always @(negedge lead)
    got <= {got[6:0], so};
  // inverted refill so a stale bit never looks valid
  always @(posedge lead or posedge load)
    if (load)
      tx_q <= word;
    else
      tx_q <= {tx_q[6:0], ~tx_q[7]};
endmodule

// ### verification/tb.sv
// self-checking bench for the three-wire serial port
// assumes a pulled-up clock line and a peer told the clock idle level
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] MA = three_wire_serial_pkg::MODE_ADDR;
  localparam logic [15:0] CA = three_wire_serial_pkg::CLKSEL_ADDR;
  localparam logic [15:0] TA = three_wire_serial_pkg::TXBUF_ADDR;
  localparam logic [15:0] SA = three_wire_serial_pkg::SHIFT_ADDR;
  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [7:0]  bus_wdata = 8'h00;
  logic [7:0]  bus_rdata;
  logic        sck_out;
  logic        sck_oe;
  logic        si;
  logic        so;
  logic        load = 1'b0;
  logic        inv = 1'b0;
  logic [7:0]  word = 8'h00;
  logic [7:0]  got;
  logic [7:0]  rd_v;
  int          fail_count = 0;
  int          comparisons = 0;
  wire         sck = sck_oe ? sck_out : 1'b1;
  always #10 clk = ~clk;
  // 16 ns half period: a link rising edge never lands on a bus rising edge
  always #16 link_clk = ~link_clk;
  three_wire_serial_port i_three_wire_serial_port (
    .clk(clk), .nrst(nrst), .link_clk(link_clk),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .serial_clock_line_in(sck), .serial_clock_line_out(sck_out),
    .serial_clock_line_oe(sck_oe), .serial_input_line(si),
    .serial_output_line(so));
  serial_peer i_serial_peer (.sck(sck), .inv(inv), .so(so), .load(load),
    .word(word), .si(si), .got(got));
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev[i] = v[7 - i];
  endfunction
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clk) #1;
    bus_wr = 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clk) #1;
    bus_rd = 1'b0;
    @(posedge clk) #1;
    v = bus_rdata;
  endtask
  task automatic expect_rd(input logic [15:0] a, input logic [7:0] e);
    rd(a, rd_v);
    cmp(rd_v, e);
  endtask
  task automatic wait_idle();
    rd_v = 8'h01;
    for (int i = 0; i < 300 && rd_v[0] !== 1'b0; i++)
      rd(MA, rd_v);
    cmp(rd_v & 8'h01, 8'h00);
  endtask
  task automatic arm(input logic [7:0] v);
    word = v;
    load = 1'b1;
    @(posedge clk) #1;
    load = 1'b0;
  endtask
  task automatic t_reset();
    expect_rd(TA, 8'h00);
    expect_rd(SA, 8'h00);
    expect_rd(MA, 8'h00);
    expect_rd(CA, 8'h00);
    expect_rd(16'hff84, 8'h00);
    wr(TA, 8'h5a);
    wr(SA, 8'h77);
    expect_rd(TA, 8'h5a);
    expect_rd(SA, 8'h00);
    // divider 2 leaves the input sync room inside a half period
    wr(CA, 8'h02);
    expect_rd(CA, 8'h02);
    $display("reset test done");
  endtask
  task automatic t_xfer(input logic l, input logic [7:0] t, r);
    arm(r);
    wr(MA, {3'b110, l, 4'h0});
    wr(TA, t);
    wait_idle();
    cmp(got, l ? rev(t) : t);
    expect_rd(SA, l ? rev(r) : r);
    $display("transfer test done");
  endtask
  task automatic t_type3(input logic [7:0] t, input logic [7:0] r);
    // clock select only changes while stopped
    wr(MA, 8'h00);
    wr(CA, 8'h12);
    inv = 1'b1;
    wr(MA, 8'hc0);
    // the pin falls to its low idle level a few link edges later
    #200;
    arm(r);
    wr(TA, t);
    wait_idle();
    cmp(got, t);
    expect_rd(SA, r);
    $display("type 3 test done");
  endtask
  task automatic t_rx_only();
    arm(8'hc3);
    wr(MA, 8'h80);
    rd(SA, rd_v);
    wait_idle();
    cmp(got, 8'h00);
    expect_rd(SA, 8'hc3);
    wait_idle();
    $display("receive test done");
  endtask
  task automatic t_stop();
    arm(8'h99);
    wr(MA, 8'hc0);
    wr(TA, 8'h3c);
    #400;
    wr(MA, 8'h00);
    expect_rd(MA, 8'h00);
    expect_rd(SA, 8'h00);
    wr(TA, 8'h66);
    expect_rd(MA, 8'h00);
    $display("stop test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    // 5 cycles still give the link side three reset edges
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_xfer(1'b0, 8'ha5, 8'h3c);
    t_xfer(1'b1, 8'h1e, 8'hc4);
    t_type3(8'h96, 8'h4b);
    t_rx_only();
    t_stop();
    give_verdict();
  end
  initial
  begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule
bind three_wire_serial_port serial_port_chk i_serial_port_chk (
  .clk, .nrst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
  .serial_clock_line_oe, .serial_output_line);
